// ---- hdl/pmc_defs.svh ----
// constants of the power-management capability register pair
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// configuration byte addresses of the two dwords of the structure
`define PMC_CAP_DWORD      8'h40
`define PMC_CSR_DWORD      8'h44
`define PMC_ADDR_W         8

// capabilities word field positions (upper half of the first dword)
`define PMC_CAP_LSB        16
`define PMC_D3C_BIT        15
`define PMC_EVENT_STATUS_BIT_MSB       14
`define PMC_EVENT_STATUS_BIT_LSB       11
`define PMC_D2S_BIT        10
`define PMC_D1S_BIT        9
`define PMC_AUX_MSB        8
`define PMC_AUX_LSB        6
`define PMC_DSI_BIT        5
`define PMC_CLK_BIT        3
`define PMC_VER_MSB        2
`define PMC_VER_LSB        0

// control/status word field positions (lower half of the second dword)
`define PMC_ST_BIT         15
`define PMC_SCALE_MSB      14
`define PMC_SCALE_LSB      13
`define PMC_SEL_MSB        12
`define PMC_SEL_LSB        9
`define PMC_EN_BIT         8
`define PMC_PS_MSB         1
`define PMC_PS_LSB         0

// fixed capability values
`define PMC_VER_VAL        3'h2
`define PMC_AUX_VAL        3'h1
`define PMC_AUX_NONE       3'h0
`define PMC_DSI_VAL        1'h0
`define PMC_CLK_VAL        1'h0
`define PMC_D1_SUP         1'h1
`define PMC_D2_SUP         1'h1
`define PMC_PME_LOW_SUP    4'hF
`define PMC_DATA_IMPL      1'h0

// reset values
`define PMC_SEL_RST        4'h0
`define PMC_SCALE_RST      2'h0
`define PMC_WORD_ZERO      32'h0000_0000
`define PMC_HALF_ZERO      16'h0000

`endif

// ---- hdl/pmc_pkg.sv ----
// types shared by the power-management capability block
package pmc_pkg;

  typedef enum logic [1:0]
  {
    PMC_D0,
    PMC_D1,
    PMC_D2,
    PMC_D3HOT
  } pmc_pstate_type;

  typedef enum logic
  {
    PMC_IDLE,
    PMC_ANSWER
  } pmc_cyc_type;

endpackage

// ---- hdl/pmc_strap.sv ----
// power-on capture of the d3cold event support strap
`timescale 1ns/10ps
`include "pmc_defs.svh"

module pmc_strap
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // strap pin
  input  wire logic d3cold_strap_pin,
  // captured value
  output logic      d3cold_event_support,
  output logic      strap_valid
);

  logic done_ff;
  logic val_ff;
  logic nxt_done;
  logic nxt_val;

  // pin is caught once on the first edge after release, never under reset
  always_comb
  begin
    nxt_done = 1'b1;
    nxt_val  = done_ff ? val_ff : d3cold_strap_pin;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      done_ff <= 1'b0;
      val_ff  <= 1'b0;
    end
    else
    begin
      done_ff <= nxt_done;
      val_ff  <= nxt_val;
    end
  end

  assign d3cold_event_support = val_ff;
  assign strap_valid          = done_ff;

endmodule

// ---- hdl/pmc_regs.sv ----
// power-management capabilities and control/status registers of one function
`timescale 1ns/10ps
`include "pmc_defs.svh"

module pmc_regs
  import pmc_pkg::*;
(
  // clock and power-on reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // function reset from the bus, synchronous, keeps sticky bits only with cold support
  input  wire logic                   func_rst_n,
  // power-on strap
  input  wire logic                   d3cold_strap_pin,
  // configuration access
  input  wire logic                   cfg_rd,
  input  wire logic                   cfg_wr,
  input  wire logic [`PMC_ADDR_W-1:0] cfg_addr,
  input  wire logic [3:0]             cfg_be,
  input  wire logic [31:0]            cfg_wdata,
  output logic      [31:0]            cfg_rdata,
  output logic                        cfg_ack,
  // wake event from the function core
  input  wire logic                   pm_event,
  // open-drain wake pin, low while enabled
  output logic                        pme_o,
  output logic                        pme_oe,
  // current power state to the function core
  output pmc_pkg::pmc_pstate_type     power_state
);

  import pmc_pkg::*;

  // strap capture
  // a strap changed after power-on is never seen; only rstn captures it again

  logic d3c_sup;
  logic strap_ok;

  pmc_strap u_strap
  (
    .clk                  (clk),
    .rstn                 (rstn),
    .d3cold_strap_pin     (d3cold_strap_pin),
    .d3cold_event_support (d3c_sup),
    .strap_valid          (strap_ok)
  );

  // decode helpers

  // a state the function cannot enter is refused on write
  function automatic logic state_ok(input logic [1:0] code);
    logic ok;
    ok = 1'b1;
    if (code == PMC_D1)
      ok = `PMC_D1_SUP;
    else if (code == PMC_D2)
      ok = `PMC_D2_SUP;
    return ok;
  endfunction

  // event support for a power state; d3cold is handled by the strap
  function automatic logic event_ok(input logic [1:0] code);
    logic [3:0] sup;
    sup = `PMC_PME_LOW_SUP;
    return sup[code];
  endfunction

  // byte-lane mask

  logic [31:0] wmask;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_lane
      assign wmask[gi*8 +: 8] = {8{cfg_be[gi]}};
    end
  endgenerate

  // capabilities word, read only

  logic        any_event;
  logic [2:0]  aux_cur;
  logic [15:0] cap_word;

  always_comb
  begin
    any_event = (|`PMC_PME_LOW_SUP) | d3c_sup;
    if (`PMC_DATA_IMPL)
      aux_cur = `PMC_AUX_NONE;
    else if (!d3c_sup)
      aux_cur = `PMC_AUX_NONE;
    else
      aux_cur = `PMC_AUX_VAL;
    cap_word                              = `PMC_HALF_ZERO;
    cap_word[`PMC_D3C_BIT]                = d3c_sup;
    cap_word[`PMC_EVENT_STATUS_BIT_MSB:`PMC_EVENT_STATUS_BIT_LSB] = `PMC_PME_LOW_SUP;
    cap_word[`PMC_D2S_BIT]                = `PMC_D2_SUP;
    cap_word[`PMC_D1S_BIT]                = `PMC_D1_SUP;
    cap_word[`PMC_AUX_MSB:`PMC_AUX_LSB]   = aux_cur;
    cap_word[`PMC_DSI_BIT]                = `PMC_DSI_VAL;
    cap_word[`PMC_CLK_BIT]                = `PMC_CLK_VAL & any_event;
    cap_word[`PMC_VER_MSB:`PMC_VER_LSB]   = `PMC_VER_VAL;
  end

  // control/status state

  pmc_pstate_type pstate_ff;
  pmc_pstate_type nxt_pstate;
  logic [3:0]     sel_ff;
  logic [3:0]     nxt_sel;
  logic           st_ff;
  logic           nxt_st;
  logic           en_ff;
  logic           nxt_en;

  logic           hit_csr;
  logic           hit_cap;
  logic           wr_csr;
  logic [31:0]    wdat;
  logic [1:0]     ps_req;
  logic           st_clr;
  logic           st_set;

  always_comb
  begin
    hit_cap = (cfg_addr == `PMC_CAP_DWORD);
    hit_csr = (cfg_addr == `PMC_CSR_DWORD);
    wr_csr  = cfg_wr & hit_csr;
    wdat    = cfg_wdata & wmask;
    ps_req  = wdat[`PMC_PS_MSB:`PMC_PS_LSB];
    st_clr  = wr_csr & cfg_be[1] & wdat[`PMC_ST_BIT];
    // events before the strap is known could follow the wrong sticky policy
    st_set  = pm_event & strap_ok & (event_ok(pstate_ff) | d3c_sup);

    nxt_pstate = pstate_ff;
    nxt_sel    = sel_ff;
    nxt_st     = st_ff;
    nxt_en     = en_ff;

    // reserved bits 7:2 are never stored, so they always read zero
    if (wr_csr & cfg_be[0] & state_ok(ps_req))
      nxt_pstate = pmc_pstate_type'(ps_req);
    // select is dead without a data register and stays at its reset value
    if (wr_csr & cfg_be[1] & `PMC_DATA_IMPL)
      nxt_sel = wdat[`PMC_SEL_MSB:`PMC_SEL_LSB];
    if (wr_csr & cfg_be[1])
      nxt_en = wdat[`PMC_EN_BIT];
    // a new event in the clearing cycle is kept
    if (st_set)
      nxt_st = 1'b1;
    else if (st_clr)
      nxt_st = 1'b0;

    // function reset: power state and select go home, sticky bits stay only with cold support
    if (!func_rst_n)
    begin
      nxt_pstate = PMC_D0;
      nxt_sel    = `PMC_SEL_RST;
      if (!d3c_sup)
      begin
        nxt_st = 1'b0;
        nxt_en = 1'b0;
      end
    end
  end

  // power-on reset always clears the sticky pair; function reset clears it only without cold support
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pstate_ff <= PMC_D0;
      sel_ff    <= `PMC_SEL_RST;
      st_ff     <= 1'b0;
      en_ff     <= 1'b0;
    end
    else
    begin
      pstate_ff <= nxt_pstate;
      sel_ff    <= nxt_sel;
      st_ff     <= nxt_st;
      en_ff     <= nxt_en;
    end
  end

  // control/status word image

  logic [15:0] csr_word;

  always_comb
  begin
    csr_word                                = `PMC_HALF_ZERO;
    csr_word[`PMC_ST_BIT]                   = st_ff;
    csr_word[`PMC_SCALE_MSB:`PMC_SCALE_LSB] = `PMC_SCALE_RST;
    csr_word[`PMC_SEL_MSB:`PMC_SEL_LSB]     = sel_ff;
    csr_word[`PMC_EN_BIT]                   = en_ff;
    csr_word[`PMC_PS_MSB:`PMC_PS_LSB]       = pstate_ff;
  end

  // configuration answer: every access is acknowledged one cycle later

  pmc_cyc_type cyc_ff;
  pmc_cyc_type nxt_cyc;
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  always_comb
  begin
    nxt_cyc   = PMC_IDLE;
    nxt_rdata = rdata_ff;
    unique case (cyc_ff)
      PMC_IDLE,
      PMC_ANSWER:
      begin
        if (cfg_rd | cfg_wr)
          nxt_cyc = PMC_ANSWER;
      end
    endcase
    // the acknowledge gets its own flop so the port does not hang off a decoder
    nxt_ack = (nxt_cyc == PMC_ANSWER);
    // unmapped dwords and left-out fields read as zero
    if (cfg_rd)
    begin
      nxt_rdata = `PMC_WORD_ZERO;
      if (hit_cap)
        nxt_rdata = {cap_word, `PMC_HALF_ZERO};
      else if (hit_csr)
        nxt_rdata = {`PMC_HALF_ZERO, csr_word};
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cyc_ff   <= PMC_IDLE;
      ack_ff   <= 1'b0;
      rdata_ff <= `PMC_WORD_ZERO;
    end
    else
    begin
      cyc_ff   <= nxt_cyc;
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // wake pin driver

  logic drive_ff;
  logic nxt_drive;
  logic po_ff;

  always_comb
  begin
    // status rises regardless of enable; only the pin is gated
    // next values keep the pin in step with the stored bits, not one edge late
    nxt_drive = nxt_st & nxt_en;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      drive_ff <= 1'b0;
      po_ff    <= 1'b0;
    end
    else
    begin
      drive_ff <= nxt_drive;
      po_ff    <= 1'b0;
    end
  end

  assign cfg_rdata   = rdata_ff;
  assign cfg_ack     = ack_ff;
  assign pme_o       = po_ff;
  assign pme_oe      = drive_ff;
  assign power_state = pstate_ff;

endmodule

// ---- bench/pmc_regs_props.sv ----
// assertions on the ports of the power-management register pair
`timescale 1ns/10ps
`include "pmc_defs.svh"
module pmc_regs_props
  import pmc_pkg::*;
(
  // clock, resets and strap pin
  input wire logic                   clk,
  input wire logic                   rstn,
  input wire logic                   func_rst_n,
  input wire logic                   d3cold_strap_pin,
  // configuration access
  input wire logic                   cfg_rd,
  input wire logic                   cfg_wr,
  input wire logic [`PMC_ADDR_W-1:0] cfg_addr,
  input wire logic [3:0]             cfg_be,
  input wire logic [31:0]            cfg_wdata,
  input wire logic [31:0]            cfg_rdata,
  input wire logic                   cfg_ack,
  // events and state
  input wire logic                   pm_event,
  input wire logic                   pme_o,
  input wire logic                   pme_oe,
  input pmc_pkg::pmc_pstate_type     power_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic cap_rd;
  logic csr_rd;
  logic csr_wr;
  assign cap_rd = cfg_rd && cfg_addr == `PMC_CAP_DWORD;
  assign csr_rd = cfg_rd && cfg_addr == `PMC_CSR_DWORD;
  assign csr_wr = cfg_wr && cfg_addr == `PMC_CSR_DWORD;
  AST_ACK_AFTER_REQ: assert property ((cfg_rd || cfg_wr) |=> cfg_ack)
    else $error("request not acknowledged");
  AST_ACK_HAS_CAUSE: assert property (cfg_ack |-> $past(cfg_rd || cfg_wr))
    else $error("acknowledge without request");
  AST_CAP_FIXED: assert property (cap_rd |=> cfg_rdata[18:16] == 3'h2
    && !cfg_rdata[19] && !cfg_rdata[21] && cfg_rdata[15:0] == 16'h0000)
    else $error("fixed capability fields wrong");
  AST_AUX_NO_D3C: assert property (cap_rd |=> cfg_rdata[31] || cfg_rdata[24:22] == 3'h0)
    else $error("aux current nonzero without cold support");
  AST_CSR_ZEROS: assert property (csr_rd |=> cfg_rdata[31:16] == 16'h0000
    && cfg_rdata[14:9] == 6'h00 && cfg_rdata[7:2] == 6'h00)
    else $error("control word constant fields wrong");
  AST_STATE_WRITE: assert property (csr_wr && cfg_be[0] && func_rst_n
    |=> power_state == $past(cfg_wdata[1:0]))
    else $error("power state not taken from write");
  AST_CAP_WRITE_IGNORED: assert property (cfg_wr && !csr_wr && func_rst_n
    |=> $stable(power_state))
    else $error("capability write changed state");
  AST_STATUS_CLEAR: assert property (csr_wr && cfg_be[1] && cfg_wdata[15] && !pm_event
    |=> !pme_oe)
    else $error("wake pin still driven after clear");
  AST_PIN_OPEN_DRAIN: assert property (pme_oe |-> !pme_o)
    else $error("wake pin driven high");
  AST_WAKE_CAUSE: assert property ($rose(pme_oe) |-> $past(pm_event || cfg_wr))
    else $error("wake pin rose without cause");
  AST_FUNC_RESET: assert property (!func_rst_n |=> power_state == PMC_D0)
    else $error("function reset left state");
  AST_ENABLE_GATES_PIN: assert property (csr_wr && cfg_be[1] && !cfg_wdata[8]
    |=> !pme_oe)
    else $error("wake pin driven with enable cleared");
  AST_ZERO_WRITE_KEEPS: assert property (csr_wr && cfg_be[1] && !cfg_wdata[15]
    && cfg_wdata[8] && pme_oe && func_rst_n |=> pme_oe)
    else $error("writing zero to status released the wake pin");
  cover property (csr_wr && cfg_be[0] && cfg_wdata[1:0] == 2'h3);
  cover property ($fell(pme_oe));
  cover property (!func_rst_n && d3cold_strap_pin);
endmodule
bind pmc_regs pmc_regs_props i_props (.clk(clk), .rstn(rstn), .func_rst_n(func_rst_n),
  .d3cold_strap_pin(d3cold_strap_pin), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
  .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .cfg_ack(cfg_ack), .pm_event(pm_event), .pme_o(pme_o), .pme_oe(pme_oe),
  .power_state(power_state));

// ---- bench/pmc_host.sv ----
// configuration-cycle master standing in for the host bridge
`timescale 1ns/10ps
`include "pmc_defs.svh"
module pmc_host
(
  // clock
  input  wire logic                   clk,
  // configuration access
  output logic                        cfg_rd,
  output logic                        cfg_wr,
  output logic [`PMC_ADDR_W-1:0]      cfg_addr,
  output logic [3:0]                  cfg_be,
  output logic [31:0]                 cfg_wdata,
  input  wire logic [31:0]            cfg_rdata,
  input  wire logic                   cfg_ack,
  // wake pin
  input  wire logic                   pme_o,
  input  wire logic                   pme_oe,
  output logic                        pme_line
);
  // board pull-up: a released pin reads high
  assign pme_line = pme_oe ? pme_o : 1'b1;
  initial
  begin
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end
  // one request pulse; the answer is taken half a cycle after the edge that took it
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d, output logic [31:0] q, output logic ok);
    @(negedge clk);
    cfg_rd = !wr;
    cfg_wr = wr;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = (a == `PMC_CSR_DWORD) ? (d & 32'hFFFF_FF03) : d;
    @(negedge clk);
    ok = cfg_ack;
    q = cfg_rdata;
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = ~a;
    cfg_wdata = ~cfg_wdata;
  endtask
endmodule

// ---- bench/tb_pmc_regs.sv ----
// self-checking bench for the power-management register pair
`timescale 1ns/10ps
`include "pmc_defs.svh"
module tb_pmc_regs import pmc_pkg::*;;
  logic                   clk = 1'b0;
  logic                   rstn = 1'b0;
  logic                   func_rst_n = 1'b1;
  logic                   strap = 1'b1;
  logic                   cfg_rd;
  logic                   cfg_wr;
  logic [`PMC_ADDR_W-1:0] cfg_addr;
  logic [3:0]             cfg_be;
  logic [31:0]            cfg_wdata;
  logic [31:0]            cfg_rdata;
  logic                   cfg_ack;
  logic                   pm_event = 1'b0;
  logic                   pme_o;
  logic                   pme_oe;
  logic                   pme_line;
  pmc_pstate_type         power_state;
  int                     n_errors = 0;
  int                     tests_run = 0;
  always #4 clk = ~clk;
  pmc_regs i_dut (.clk(clk), .rstn(rstn), .func_rst_n(func_rst_n), .d3cold_strap_pin(strap),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .pm_event(pm_event),
    .pme_o(pme_o), .pme_oe(pme_oe), .power_state(power_state));
  pmc_host i_host (.clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .pme_o(pme_o), .pme_oe(pme_oe), .pme_line(pme_line));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        ok;
    i_host.xfer(1'b0, a, 4'hF, 32'h0000_0000, q, ok);
    check({31'h0, ok}, 32'h0000_0001);
    check(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    logic        ok;
    i_host.xfer(1'b1, a, be, d, q, ok);
    check({31'h0, ok}, 32'h0000_0001);
  endtask
  task automatic power_on(input logic s);
    @(negedge clk);
    rstn = 1'b0;
    strap = s;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
  endtask
  task automatic wake(input logic exp_line);
    @(negedge clk);
    pm_event = 1'b1;
    @(negedge clk);
    pm_event = 1'b0;
    check({31'h0, pme_line}, {31'h0, exp_line});
  endtask
  task automatic func_reset;
    @(negedge clk);
    func_rst_n = 1'b0;
    @(negedge clk);
    func_rst_n = 1'b1;
  endtask
  // strap level decides cold support and with it the aux current code
  task automatic t_caps(input logic s);
    power_on(s);
    rd(`PMC_CAP_DWORD, s ? 32'hFE42_0000 : 32'h7E02_0000);
    rd(`PMC_CSR_DWORD, 32'h0000_0000);
    wr(`PMC_CAP_DWORD, 4'hF, 32'hFFFF_FFFF);
    rd(`PMC_CAP_DWORD, s ? 32'hFE42_0000 : 32'h7E02_0000);
    rd(8'h48, 32'h0000_0000);
  endtask
  task automatic t_states;
    for (int i = 3; i >= 0; i--)
    begin
      wr(`PMC_CSR_DWORD, 4'h1, i);
      rd(`PMC_CSR_DWORD, i);
      check({30'h0, power_state}, i);
    end
    wr(`PMC_CSR_DWORD, 4'h1, 32'h0000_0002);
    func_reset;
    check({30'h0, power_state}, 32'h0000_0000);
  endtask
  task automatic t_event;
    wr(`PMC_CSR_DWORD, 4'h2, 32'h0000_0100);
    wake(1'b0);
    rd(`PMC_CSR_DWORD, 32'h0000_8100);
    wr(`PMC_CSR_DWORD, 4'h2, 32'h0000_0100);
    check({31'h0, pme_line}, 32'h0000_0000);
    wr(`PMC_CSR_DWORD, 4'h2, 32'h0000_8100);
    check({31'h0, pme_line}, 32'h0000_0001);
    rd(`PMC_CSR_DWORD, 32'h0000_0100);
    wr(`PMC_CSR_DWORD, 4'h2, 32'h0000_0000);
    wake(1'b1);
    rd(`PMC_CSR_DWORD, 32'h0000_8000);
    wr(`PMC_CSR_DWORD, 4'h2, 32'h0000_8000);
    rd(`PMC_CSR_DWORD, 32'h0000_0000);
  endtask
  // sticky bits survive a function reset only with cold support
  task automatic t_sticky(input logic s);
    wr(`PMC_CSR_DWORD, 4'h3, 32'h0000_0103);
    wake(1'b0);
    func_reset;
    rd(`PMC_CSR_DWORD, s ? 32'h0000_8100 : 32'h0000_0000);
    check({31'h0, pme_line}, {31'h0, ~s});
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_errors++;
    final_report;
  end
  initial
  begin
    t_caps(1'b1);
    t_states;
    t_event;
    t_sticky(1'b1);
    t_caps(1'b0);
    t_sticky(1'b0);
    final_report;
  end
endmodule
